/* File: tbr_trace_readout.v */
`timescale 1ns/1ps
// Behaviour
// - data reads allowed only disarmed, tracing, unsecured
// - writing arm bit one locks buffer
// - aligned word write to data unlocks, only while disarmed
// - byte or misaligned data and count reads return zero
// - lines delivered oldest first
// - count reports valid lines, reloaded only at session end, not decremented by reads
// - pointer starts at oldest surviving line
// - aligned write to high word rewinds pointer
// - info bits 6,2 give access size
// - info bits 5,1 give direction
// - info bits 4,0 flag opcode fetch
// - info bit 3 flags real coprocessor cycle
// - info bits valid only in detail mode
module tbr_trace_readout (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // debug module state
    input wire arm_write_in,
    input wire arm_value_in,
    input wire armed_in,
    input wire trace_cfg_in,
    input wire secured_in,
    input wire detail_mode_in,
    // capture side: line store and session end
    input wire cap_we_in,
    input wire [5:0] cap_addr_in,
    input wire [63:0] cap_line_in,
    input wire [7:0] cap_info_in,
    input wire session_end_in,
    input wire overflow_in,
    input wire [5:0] oldest_in,
    input wire [6:0] valid_count_in,
    // register port
    input wire reg_sel_in,
    input wire reg_wr_in,
    input wire [3:0] reg_addr_in,
    input wire reg_word_in,
    input wire [15:0] reg_wdata_in,
    output reg [15:0] reg_rdata_out,
    // status
    output wire read_open_out,
    output reg [5:0] read_ptr_out,
    output reg [6:0] valid_line_count_out
);
`include "tbr_map.vh"
    reg [63:0] trace_mem [0:63];
    reg [7:0] info_mem [0:63];
    reg unlocked;
    reg [1:0] word_sel;
    reg [5:0] oldest;
    wire [7:0] trace_line_access_info;
    wire aligned;
    wire rd_data;
    wire rd_info;
    wire [63:0] cur_line;
    wire [15:0] cur_word;

    function is_reg;
        input [3:0] a;
        input [3:0] off;
        begin
            is_reg = (a[3:1] == off[3:1]);
        end
    endfunction

    // word access at even address is the only aligned form
    assign aligned = reg_word_in && !reg_addr_in[0];
    assign read_open_out = unlocked && !armed_in && trace_cfg_in &&
                           !secured_in;
    assign rd_data = reg_sel_in && !reg_wr_in && aligned && read_open_out &&
                     (is_reg(reg_addr_in, `TBR_OFF_DATA) ||
                      is_reg(reg_addr_in, `TBR_OFF_DATA_HIGH));
    assign rd_info = reg_sel_in && !reg_wr_in &&
                     is_reg(reg_addr_in, `TBR_OFF_INFO);
    assign cur_line = trace_mem[read_ptr_out];
    // high word first, so the first data read of each line returns bits 63:48
    assign cur_word = (word_sel == 2'd0) ? cur_line[63:48] :
                      (word_sel == 2'd1) ? cur_line[47:32] :
                      (word_sel == 2'd2) ? cur_line[31:16] :
                      cur_line[15:0];

    tbr_info_pack u_pack (
        .cpu_size_in(info_mem[read_ptr_out][`TBR_CPU_SIZE_BIT]),
        .cpu_dir_in(info_mem[read_ptr_out][`TBR_CPU_DIR_BIT]),
        .cpu_fetch_in(info_mem[read_ptr_out][`TBR_CPU_FETCH_BIT]),
        .co_real_in(info_mem[read_ptr_out][`TBR_CO_REAL_BIT]),
        .co_size_in(info_mem[read_ptr_out][`TBR_CO_SIZE_BIT]),
        .co_dir_in(info_mem[read_ptr_out][`TBR_CO_DIR_BIT]),
        .co_fetch_in(info_mem[read_ptr_out][`TBR_CO_FETCH_BIT]),
        .info_out(trace_line_access_info)
    );

    always @(posedge clk_in) begin
        if (cap_we_in) begin
            trace_mem[cap_addr_in] <= cap_line_in;
            // outside detail mode the flags carry no meaning; store zero
            info_mem[cap_addr_in] <= detail_mode_in ? cap_info_in :
                                     `TBR_RST_INFO;
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            unlocked <= 1'b0;
            word_sel <= 2'd0;
            oldest <= `TBR_RST_PTR;
            read_ptr_out <= `TBR_RST_PTR;
            valid_line_count_out <= `TBR_RST_COUNT;
            reg_rdata_out <= `TBR_RST_WORD;
        end else begin
            if (arm_write_in && arm_value_in) begin
                unlocked <= 1'b0;
            end else if (reg_sel_in && reg_wr_in && aligned && !armed_in &&
                         is_reg(reg_addr_in, `TBR_OFF_DATA)) begin
                unlocked <= 1'b1;
            end
            if (session_end_in) begin
                oldest <= overflow_in ? oldest_in : `TBR_RST_PTR;
                read_ptr_out <= overflow_in ? oldest_in :
                                `TBR_RST_PTR;
                valid_line_count_out <= valid_count_in;
                word_sel <= 2'd0;
            end else if (reg_sel_in && reg_wr_in && aligned &&
                         is_reg(reg_addr_in, `TBR_OFF_DATA_HIGH)) begin
                read_ptr_out <= oldest;
                word_sel <= 2'd0;
            end else if (rd_data) begin
                word_sel <= word_sel + 2'd1;
                if (word_sel == 2'd3) begin
                    read_ptr_out <= read_ptr_out + 6'd1;
                end
            end
            if (rd_data) begin
                reg_rdata_out <= cur_word;
            end else if (rd_info) begin
                reg_rdata_out <= {8'h00, trace_line_access_info};
            end else if (reg_sel_in && !reg_wr_in && aligned &&
                         is_reg(reg_addr_in, `TBR_OFF_COUNT)) begin
                reg_rdata_out <= {9'h000, valid_line_count_out};
            end else begin
                reg_rdata_out <= `TBR_RST_WORD;
            end
        end
    end
endmodule

/* File: tbr_map.vh */
`ifndef TBR_MAP_VH
`define TBR_MAP_VH
// register indices on the debug register port (word addressed by byte addr)
`define TBR_ADDR_W 4
`define TBR_OFF_DATA_HIGH 4'h0
`define TBR_OFF_DATA 4'h2
`define TBR_OFF_COUNT 4'h4
`define TBR_OFF_INFO 4'h6
// trace memory geometry
`define TBR_LINES 64
`define TBR_PTR_W 6
`define TBR_LINE_W 64
`define TBR_WORDS 4
`define TBR_WORD_SEL_W 2
// access info byte fields
`define TBR_CPU_SIZE_BIT 6
`define TBR_CPU_DIR_BIT 5
`define TBR_CPU_FETCH_BIT 4
`define TBR_CO_REAL_BIT 3
`define TBR_CO_SIZE_BIT 2
`define TBR_CO_DIR_BIT 1
`define TBR_CO_FETCH_BIT 0
// reset values
`define TBR_RST_WORD 16'h0000
`define TBR_RST_INFO 8'h00
`define TBR_RST_PTR 6'h00
`define TBR_RST_COUNT 7'h00
`endif

/* File: tbr_info_pack.v */
`timescale 1ns/1ps
module tbr_info_pack (
    // cpu side flags
    input wire cpu_size_in,
    input wire cpu_dir_in,
    input wire cpu_fetch_in,
    // coprocessor side flags
    input wire co_real_in,
    input wire co_size_in,
    input wire co_dir_in,
    input wire co_fetch_in,
    // packed byte
    output wire [7:0] info_out
);
`include "tbr_map.vh"
    // bit 7 unused, reads zero
    assign info_out = {1'b0, cpu_size_in, cpu_dir_in, cpu_fetch_in,
                       co_real_in, co_size_in, co_dir_in,
                       co_fetch_in};
endmodule

/* File: tbr_props.sv */
`timescale 1ns/1ps
module tbr_props (
    // watched ports
    input wire clk_in, rst_in, arm_write_in, arm_value_in, armed_in,
    input wire trace_cfg_in, secured_in, session_end_in, overflow_in,
    input wire reg_sel_in, reg_wr_in, reg_word_in, read_open_out,
    input wire [3:0] reg_addr_in,
    input wire [5:0] oldest_in, read_ptr_out,
    input wire [15:0] reg_rdata_out,
    input wire [6:0] valid_line_count_out
);
    // oldest line of the last session, the place a rewind must return to
    reg [5:0] st;
    wire rd = reg_sel_in && !reg_wr_in;
    wire wa = reg_sel_in && reg_wr_in && reg_word_in;
    wire ok = !armed_in && trace_cfg_in && !secured_in;
    always @(posedge clk_in or posedge rst_in)
        if (rst_in) st <= 6'h00;
        else if (session_end_in) st <= overflow_in ? oldest_in : 6'h00;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_open_gate: assert property (read_open_out |-> ok)
        else $error("open while blocked");
    a_lock_zero: assert property (!read_open_out && rd
        && reg_addr_in[3:2] == 2'b00 |=> !reg_rdata_out)
        else $error("locked data");
    a_arm_locks: assert property (arm_write_in && arm_value_in
        |=> !read_open_out) else $error("arm kept open");
    a_unlock_opens: assert property (wa && reg_addr_in == 4'h2
        && ok && !arm_write_in |=> read_open_out || !ok) else $error("shut");
    a_odd_zero: assert property (rd && (!reg_word_in || reg_addr_in[0])
        && reg_addr_in[3:2] == 2'b00 && !session_end_in
        |=> !reg_rdata_out && $stable(read_ptr_out)) else $error("odd read");
    a_count_held: assert property (!session_end_in
        |=> $stable(valid_line_count_out)) else $error("count moved");
    a_sess_ptr: assert property (session_end_in |=> read_ptr_out == st)
        else $error("not oldest");
    a_rewind_ptr: assert property (wa && reg_addr_in == 4'h0
        && !session_end_in |=> read_ptr_out == st) else $error("no rewind");
    c_read: cover property (rd && read_open_out);
    c_odd: cover property (rd && reg_addr_in[0]);
    c_ovf: cover property (session_end_in && overflow_in);
endmodule
bind tbr_trace_readout tbr_props u_props (.*);

/* File: tbr_reader.sv */
`timescale 1ns/1ps
module tbr_reader (
    input wire clk_in,
    input wire [15:0] rdata_in,
    output reg sel_out = 0,
    output reg wr_out = 0,
    output reg word_out = 0,
    output reg [3:0] addr_out = 4'h0,
    output reg [15:0] wdata_out = 16'h0
);
    // one strobed access, held until the edge that takes it
    task acc(input w, input [3:0] a, input wd, output [15:0] d);
        @(posedge clk_in) #2;
        {sel_out, wr_out, addr_out, word_out} = {1'b1, w, a, wd};
        wdata_out = ~wdata_out;
        @(posedge clk_in) #2;
        d = rdata_in;
        sel_out = 1'b0;
    endtask
endmodule

/* File: tbr_trace_readout_tb.sv */
`timescale 1ns/1ps
module tbr_trace_readout_tb;
    reg clk_in = 0, rst_in = 1, arm_write_in = 0, arm_value_in = 0;
    reg armed_in = 0, trace_cfg_in = 1, secured_in = 0, detail_mode_in = 1;
    reg cap_we_in = 0, session_end_in = 0, overflow_in = 0;
    reg [5:0] cap_addr_in = 0, oldest_in = 0;
    reg [63:0] cap_line_in = 0, mem [0:63];
    reg [7:0] cap_info_in = 0, inf [0:63];
    wire reg_sel_in, reg_wr_in, reg_word_in, read_open_out;
    wire [3:0] reg_addr_in;
    wire [15:0] reg_wdata_in, reg_rdata_out;
    wire [5:0] read_ptr_out;
    wire [6:0] valid_line_count_out;
    reg [15:0] d;
    integer seed = 32'h332b, fails = 0, cmp_count = 0, cyc = 0, i, k, p;
    tbr_trace_readout dut (.*, .valid_count_in(7'h40));
    tbr_reader rdr (.clk_in(clk_in), .rdata_in(reg_rdata_out),
        .sel_out(reg_sel_in), .wr_out(reg_wr_in), .word_out(reg_word_in),
        .addr_out(reg_addr_in), .wdata_out(reg_wdata_in));
    initial forever #50 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            fails = fails + 1;
            summarize;
        end
    end
    function [15:0] wexp(input integer l, input integer w);
        wexp = mem[l][63 - 16 * w -: 16];
    endfunction
    task chk(input [15:0] e, input [15:0] g);
        cmp_count = cmp_count + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask
    task summarize;
        $display("fails %0d compares %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_in);
        #2 rst_in = 0;
        for (i = 0; i < 64; i = i + 1) begin
            @(posedge clk_in) #2;
            {cap_we_in, cap_addr_in} = {1'b1, i[5:0]};
            cap_line_in = {$random(seed), $random(seed)};
            cap_info_in = $random(seed);
            mem[i] = cap_line_in;
            inf[i] = cap_info_in;
        end
        @(posedge clk_in) #2;
        {cap_we_in, session_end_in, overflow_in} = 3'b011;
        oldest_in = $random(seed);
        @(posedge clk_in) #2;
        session_end_in = 0;
        chk({10'h0, oldest_in}, {10'h0, read_ptr_out});
        rdr.acc(0, 4'h2, 1, d);
        chk(16'h0, d);
        rdr.acc(1, 4'h2, 1, d);
        for (k = 0; k < 3; k = k + 1) begin
            p = (oldest_in + k) % 64;
            rdr.acc(0, 4'h6, 1, d);
            chk({9'h0, inf[p][6:0]}, d);
            rdr.acc(0, 4'h3, 1, d);
            chk(16'h0, d);
            rdr.acc(0, 4'h2, 0, d);
            chk(16'h0, d);
            for (i = 0; i < 4; i = i + 1) begin
                rdr.acc(0, 4'h2, 1, d);
                chk(wexp(p, i), d);
            end
        end
        chk(16'h40, {9'h0, valid_line_count_out});
        rdr.acc(1, 4'h0, 1, d);
        rdr.acc(0, 4'h2, 1, d);
        chk(wexp(oldest_in, 0), d);
        @(posedge clk_in) #2;
        {arm_write_in, arm_value_in, armed_in} = 3'b111;
        @(posedge clk_in) #2;
        arm_write_in = 0;
        rdr.acc(1, 4'h2, 1, d);
        armed_in = 0;
        rdr.acc(0, 4'h2, 1, d);
        chk(16'h0, d);
        rdr.acc(1, 4'h2, 1, d);
        secured_in = 1;
        rdr.acc(0, 4'h2, 1, d);
        chk(16'h0, d);
        @(posedge clk_in) #2;
        {secured_in, detail_mode_in} = 2'b00;
        {cap_we_in, cap_addr_in, cap_info_in} = {1'b1, 6'h00, 8'hff};
        @(posedge clk_in) #2;
        {cap_we_in, session_end_in, overflow_in} = 3'b010;
        @(posedge clk_in) #2;
        session_end_in = 0;
        chk(16'h0, {10'h0, read_ptr_out});
        rdr.acc(0, 4'h6, 1, d);
        chk(16'h0, d);
        summarize;
    end
endmodule
